// [verilog/bst_pkg.sv]
package bst_pkg;

  // ****************************************
  // instruction register
  // ****************************************
  localparam int IR_W = 4;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam logic [3:0] IR_SAMPLE = 4'h2;
  localparam logic [3:0] IR_FLOAT_OUTPUTS_BYPASS = 4'h3;
  localparam logic [3:0] IR_DRIVE_CELLS_BYPASS = 4'h4;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // ****************************************
  // identity register layout and defaults
  // ****************************************
  localparam int ID_W = 32;
  localparam logic [3:0] ID_VERSION_DFLT = 4'h1;   // arbitrary value
  localparam logic [15:0] ID_PART_DFLT = 16'h5A5A; // arbitrary value
  localparam logic [10:0] ID_MAKER_DFLT = 11'h155; // arbitrary value
  localparam int BST_CELLS_DFLT = 8;

  // ****************************************
  // controller states, one-hot
  // ****************************************
  typedef enum logic [15:0] {
    ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SDS = 16'h0004, ST_CDR = 16'h0008,
    ST_SHDR = 16'h0010, ST_E1DR = 16'h0020, ST_PDR = 16'h0040, ST_E2DR = 16'h0080,
    ST_UDR = 16'h0100, ST_SIS = 16'h0200, ST_CIR = 16'h0400, ST_SHIR = 16'h0800,
    ST_E1IR = 16'h1000, ST_PIR = 16'h2000, ST_E2IR = 16'h4000, ST_UIR = 16'h8000
  } bst_state_e;

  // decoded instruction: {select boundary, select identity, test mode, float}
  function automatic logic [3:0] bst_decode(input logic [3:0] ir);
    logic [3:0] d;
    unique case (ir)
      IR_EXTEST: d = 4'b1010;
      IR_SAMPLE: d = 4'b1000;
      IR_IDCODE: d = 4'b0100;
      IR_FLOAT_OUTPUTS_BYPASS: d = 4'b0001;
      IR_DRIVE_CELLS_BYPASS: d = 4'b0010;
      default: d = 4'b0000; // reserved codes and bypass: one-bit path, normal mode
    endcase
    return d;
  endfunction

endpackage

// [verilog/bst_cell.sv]
`timescale 1ns/1ps
// ****************************************
// one boundary cell: shift stage and held output stage
// ****************************************
module bst_cell import bst_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic capture_en_in,
  input wire logic shift_en_in,
  input wire logic update_en_in,
  input wire logic test_mode_in,
  input wire logic scan_in,
  input wire logic observe_in,
  input wire logic sys_val_in,
  output logic scan_out,
  output logic par_out
);
  logic shift_ff;
  logic hold_ff;
  logic nxt_shift;
  logic nxt_hold;

  // capture or shift into the serial stage; update copies to the hold stage
  always_comb begin
    nxt_shift = shift_ff;
    nxt_hold = hold_ff;
    if (capture_en_in) begin
      nxt_shift = observe_in;
    end else if (shift_en_in) begin
      nxt_shift = scan_in;
    end
    // enabled register stands in for the latch so the cell stays on one clock
    if (update_en_in) begin
      nxt_hold = shift_ff;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      shift_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      shift_ff <= nxt_shift;
      hold_ff <= nxt_hold;
    end
  end

  assign scan_out = shift_ff;
  // normal mode passes the system value straight through
  assign par_out = test_mode_in ? hold_ff : sys_val_in;

endmodule

// [verilog/bst_tap.sv]
`timescale 1ns/1ps
// ****************************************
// boundary-scan test access port
// ****************************************
module bst_tap import bst_pkg::*; #(
  parameter int NUM_CELLS = BST_CELLS_DFLT,
  parameter logic [3:0] ID_VERSION = ID_VERSION_DFLT,
  parameter logic [15:0] ID_PART = ID_PART_DFLT,
  parameter logic [10:0] ID_MAKER = ID_MAKER_DFLT
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic sw_reset_in,
  input wire logic por_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  input wire logic [NUM_CELLS-1:0] pad_val_in,
  input wire logic [NUM_CELLS-1:0] core_val_in,
  input wire logic [NUM_CELLS-1:0] core_oe_in,
  output logic [NUM_CELLS-1:0] pad_val_out,
  output logic [NUM_CELLS-1:0] pad_oe_out
);

  // refused at elaboration: the chain needs at least one cell
  if (NUM_CELLS < 1) begin : g_bad_cells
    $error("NUM_CELLS must be at least 1");
  end

  localparam logic [31:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  // ****************************************
  // pin synchronisers and test clock edges
  // ****************************************
  logic tck_s1_ff, tck_s2_ff, tck_d3_ff;
  logic tms_s1_ff, tms_s2_ff;
  logic tdi_s1_ff, tdi_s2_ff;
  logic por_s1_ff, por_s2_ff;
  logic [NUM_CELLS-1:0] pad_s1_ff;
  logic [NUM_CELLS-1:0] pad_s2_ff;

  // two flops per pin; edge detect reads only the second stage onward
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      {tck_s1_ff, tck_s2_ff, tck_d3_ff} <= 3'h7;
      {tms_s1_ff, tms_s2_ff, tdi_s1_ff, tdi_s2_ff} <= 4'hF;
      {por_s1_ff, por_s2_ff} <= 2'h0;
      pad_s1_ff <= '0;
      pad_s2_ff <= '0;
    end else begin
      {tck_s1_ff, tck_s2_ff, tck_d3_ff} <= {tck_in, tck_s1_ff, tck_s2_ff};
      {tms_s1_ff, tms_s2_ff} <= {tms_in, tms_s1_ff};
      {tdi_s1_ff, tdi_s2_ff} <= {tdi_in, tdi_s1_ff};
      {por_s1_ff, por_s2_ff} <= {por_in, por_s1_ff};
      pad_s1_ff <= pad_val_in;
      pad_s2_ff <= pad_s1_ff;
    end
  end

  logic tck_rise, tck_fall, soft_clear;
  assign tck_rise = tck_s2_ff & ~tck_d3_ff;
  assign tck_fall = ~tck_s2_ff & tck_d3_ff;
  // no sleep input here: the port keeps working while the core sleeps
  assign soft_clear = sw_reset_in | por_s2_ff;

  // ****************************************
  // controller state
  // ****************************************
  bst_state_e state_ff, nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (soft_clear) begin
      nxt_state = ST_TLR;
    end else if (tck_rise) begin
      unique case (state_ff)
        ST_TLR: nxt_state = tms_s2_ff ? ST_TLR : ST_RTI;
        ST_RTI: nxt_state = tms_s2_ff ? ST_SDS : ST_RTI;
        ST_SDS: nxt_state = tms_s2_ff ? ST_SIS : ST_CDR;
        ST_CDR: nxt_state = tms_s2_ff ? ST_E1DR : ST_SHDR;
        ST_SHDR: nxt_state = tms_s2_ff ? ST_E1DR : ST_SHDR;
        ST_E1DR: nxt_state = tms_s2_ff ? ST_UDR : ST_PDR;
        ST_PDR: nxt_state = tms_s2_ff ? ST_E2DR : ST_PDR;
        ST_E2DR: nxt_state = tms_s2_ff ? ST_UDR : ST_SHDR;
        ST_UDR: nxt_state = tms_s2_ff ? ST_SDS : ST_RTI;
        ST_SIS: nxt_state = tms_s2_ff ? ST_TLR : ST_CIR;
        ST_CIR: nxt_state = tms_s2_ff ? ST_E1IR : ST_SHIR;
        ST_SHIR: nxt_state = tms_s2_ff ? ST_E1IR : ST_SHIR;
        ST_E1IR: nxt_state = tms_s2_ff ? ST_UIR : ST_PIR;
        ST_PIR: nxt_state = tms_s2_ff ? ST_E2IR : ST_PIR;
        ST_E2IR: nxt_state = tms_s2_ff ? ST_UIR : ST_SHIR;
        ST_UIR: nxt_state = tms_s2_ff ? ST_SDS : ST_RTI;
        default: nxt_state = ST_TLR; // illegal one-hot code recovers to reset
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_ff <= ST_TLR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // instruction register and decode
  // ****************************************
  logic [IR_W-1:0] ir_sh_ff, ir_ff, nxt_ir_sh, nxt_ir;
  logic [3:0] dec;
  logic sel_bnd, sel_id, test_mode, float_out;
  assign dec = bst_decode(ir_ff);
  assign {sel_bnd, sel_id, test_mode, float_out} = dec;

  always_comb begin
    nxt_ir_sh = ir_sh_ff;
    nxt_ir = ir_ff;
    if (soft_clear || state_ff == ST_TLR) begin
      nxt_ir = IR_IDCODE;
    end else if (tck_rise && state_ff == ST_CIR) begin
      nxt_ir_sh = IR_CAPTURE;
    end else if (tck_rise && state_ff == ST_SHIR) begin
      nxt_ir_sh = {tdi_s2_ff, ir_sh_ff[IR_W-1:1]};
    end else if (tck_fall && state_ff == ST_UIR) begin
      nxt_ir = ir_sh_ff;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ir_sh_ff <= IR_CAPTURE;
      ir_ff <= IR_IDCODE;
    end else begin
      ir_sh_ff <= nxt_ir_sh;
      ir_ff <= nxt_ir;
    end
  end

  // ****************************************
  // data registers: bypass, identity, boundary chain
  // ****************************************
  logic byp_ff, nxt_byp;
  logic [ID_W-1:0] id_sh_ff, nxt_id_sh;
  logic cap_bnd, shift_bnd, upd_bnd;
  logic [NUM_CELLS:0] chain;
  logic [NUM_CELLS-1:0] cell_par;

  // boundary and identity strobes gated by their selects; the bypass bit captures and shifts under every instruction
  assign cap_bnd = tck_rise & (state_ff == ST_CDR) & sel_bnd;
  assign shift_bnd = tck_rise & (state_ff == ST_SHDR) & sel_bnd;
  assign upd_bnd = tck_fall & (state_ff == ST_UDR) & sel_bnd;

  always_comb begin
    nxt_byp = byp_ff;
    nxt_id_sh = id_sh_ff;
    if (tck_rise && state_ff == ST_CDR) begin
      nxt_byp = 1'b0;
      if (sel_id) begin
        nxt_id_sh = ID_WORD;
      end
    end else if (tck_rise && state_ff == ST_SHDR) begin
      nxt_byp = tdi_s2_ff;
      if (sel_id) begin
        nxt_id_sh = {tdi_s2_ff, id_sh_ff[ID_W-1:1]};
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      byp_ff <= 1'b0;
      id_sh_ff <= ID_WORD;
    end else begin
      byp_ff <= nxt_byp;
      id_sh_ff <= nxt_id_sh;
    end
  end

  // one cell per covered pin, chain shifts from tdi toward cell 0
  assign chain[NUM_CELLS] = tdi_s2_ff;
  for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
    bst_cell u_cell (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .capture_en_in(cap_bnd),
      .shift_en_in(shift_bnd),
      .update_en_in(upd_bnd),
      .test_mode_in(test_mode),
      .scan_in(chain[i+1]),
      .observe_in(pad_s2_ff[i]),
      .sys_val_in(core_val_in[i]),
      .scan_out(chain[i]),
      .par_out(cell_par[i])
    );
  end

  // ****************************************
  // pin drive and test data out
  // ****************************************
  logic [NUM_CELLS-1:0] pad_val_ff, pad_oe_ff, nxt_pad_val, nxt_pad_oe;
  logic tdo_ff, tdo_oe_ff, nxt_tdo, nxt_tdo_oe;

  always_comb begin
    nxt_pad_val = cell_par;
    nxt_pad_oe = core_oe_in;
    if (float_out) begin
      nxt_pad_oe = '0;
    end else if (test_mode) begin
      nxt_pad_oe = '1;
    end
    nxt_tdo = tdo_ff;
    nxt_tdo_oe = tdo_oe_ff;
    // shift state holds over the falling edge, so data is valid before the next rise
    if (tck_fall) begin
      nxt_tdo_oe = (state_ff == ST_SHIR) || (state_ff == ST_SHDR);
      if (state_ff == ST_SHIR) begin
        nxt_tdo = ir_sh_ff[0];
      end else if (state_ff == ST_SHDR) begin
        nxt_tdo = sel_bnd ? chain[0] : (sel_id ? id_sh_ff[0] : byp_ff);
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pad_val_ff <= '0;
      pad_oe_ff <= '0;
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      pad_val_ff <= nxt_pad_val;
      pad_oe_ff <= nxt_pad_oe;
      tdo_ff <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
    end
  end

  assign pad_val_out = pad_val_ff;
  assign pad_oe_out = pad_oe_ff;
  assign tdo_out = tdo_ff;
  assign tdo_oe_out = tdo_oe_ff;

  // ****************************************
  // checks
  // ****************************************
  property p_hw_reset_tlr;
    @(posedge sys_clk_in) rst_in |=> (state_ff == ST_TLR) && (ir_ff == IR_IDCODE);
  endproperty
  a_hw_reset_tlr: assert property (p_hw_reset_tlr) else $error("no reset state");

  property p_por_tlr;
    @(posedge sys_clk_in) disable iff (rst_in) por_s2_ff |=> state_ff == ST_TLR;
  endproperty
  a_por_tlr: assert property (p_por_tlr) else $error("power-on missed");

  property p_sw_idcode;
    @(posedge sys_clk_in) disable iff (rst_in) sw_reset_in |=> ##1 ir_ff == IR_IDCODE;
  endproperty
  a_sw_idcode: assert property (p_sw_idcode) else $error("idcode not loaded");

  property p_state_on_rise;
    @(posedge sys_clk_in) disable iff (rst_in)
      !tck_rise && !soft_clear |=> $stable(state_ff);
  endproperty
  a_state_on_rise: assert property (p_state_on_rise) else $error("state moved");

  property p_tdo_on_fall;
    @(posedge sys_clk_in) disable iff (rst_in) $changed(tdo_ff) |-> $past(tck_fall);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo off fall");

  property p_ir_update;
    @(posedge sys_clk_in) disable iff (rst_in)
      $changed(ir_ff) |-> $past(tck_fall && state_ff == ST_UIR) ||
        $past(soft_clear || state_ff == ST_TLR);
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("ir changed early");

  property p_bypass_bit;
    @(posedge sys_clk_in) disable iff (rst_in)
      tck_rise && state_ff == ST_SHDR && !soft_clear |=> byp_ff == $past(tdi_s2_ff);
  endproperty
  a_bypass_bit: assert property (p_bypass_bit) else $error("bypass bad");

  property p_id_capture;
    @(posedge sys_clk_in) disable iff (rst_in)
      tck_rise && state_ff == ST_CDR && sel_id && !soft_clear |=> id_sh_ff == ID_WORD;
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("id capture bad");

  property p_float;
    @(posedge sys_clk_in) disable iff (rst_in)
      ir_ff == IR_FLOAT_OUTPUTS_BYPASS |=> pad_oe_out == '0;
  endproperty
  a_float: assert property (p_float) else $error("outputs not floated");

  property p_drive_cells;
    @(posedge sys_clk_in) disable iff (rst_in)
      ir_ff == IR_DRIVE_CELLS_BYPASS |=> pad_oe_out == '1 && pad_val_out == $past(cell_par);
  endproperty
  a_drive_cells: assert property (p_drive_cells) else $error("cells not driven");

endmodule

// [testbench/bst_jtag_host.sv]
`timescale 1ns/1ps
// ****************************************
// board test controller driving the scan port
// ****************************************
module bst_jtag_host import bst_pkg::*; (
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in,
  input wire logic tdo_oe_in
);
  // clock stands high between frames; released lines sit at their pull-up level
  initial begin
    tck_out = 1'b1;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end

  // one test clock: fall, sample at end of low phase, rise
  task automatic bit_cycle(input logic tms, input logic tdi, output logic tdo, output logic oe);
    tms_out = tms;
    tdi_out = tdi;
    tck_out = 1'b0;
    #32;
    // an undriven line has no pull-up: model it as the wrong level
    tdo = tdo_oe_in ? tdo_in : ~tdo_in;
    oe = tdo_oe_in;
    tck_out = 1'b1;
    #32;
  endtask

  // from test-logic-reset to run-test-idle
  task automatic go_idle();
    logic t;
    logic o;
    bit_cycle(1'b0, 1'b1, t, o);
  endtask

  // full scan from idle back to idle, lsb first; oe reports enable over the shift
  task automatic scan(input logic is_ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout, output logic oe);
    logic t;
    logic o;
    int i;
    dout = '0;
    oe = 1'b1;
    bit_cycle(1'b1, 1'b1, t, o);
    if (is_ir) begin
      bit_cycle(1'b1, 1'b1, t, o);
    end
    bit_cycle(1'b0, 1'b1, t, o);
    bit_cycle(1'b0, 1'b1, t, o);
    for (i = 0; i < n; i++) begin
      bit_cycle(i == n - 1, din[i], t, o);
      dout[i] = t;
      oe = oe & o;
    end
    bit_cycle(1'b1, 1'b1, t, o);
    bit_cycle(1'b0, 1'b1, t, o);
    tms_out = 1'b1;
    tdi_out = 1'b1;
  endtask
endmodule

// [testbench/bst_tap_tb_top.sv]
`timescale 1ns/1ps
module bst_tap_tb_top import bst_pkg::*;;
  localparam int N = 8;
  localparam logic [31:0] ID_EXP = {ID_VERSION_DFLT, ID_PART_DFLT, ID_MAKER_DFLT, 1'b1};
  logic sys_clk_in, rst_in, sw_reset_in, por_in, tck, tms, tdi, tdo, tdo_oe;
  logic [N-1:0] pad_val_in, core_val_in, core_oe_in, pad_val_out, pad_oe_out;
  int err_count, comparisons;

  bst_tap #(.NUM_CELLS(N)) bst_tap_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .sw_reset_in(sw_reset_in), .por_in(por_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .tdo_out(tdo), .tdo_oe_out(tdo_oe), .pad_val_in(pad_val_in), .core_val_in(core_val_in),
    .core_oe_in(core_oe_in), .pad_val_out(pad_val_out), .pad_oe_out(pad_oe_out));

  bst_jtag_host bst_jtag_host_i (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
    .tdo_in(tdo), .tdo_oe_in(tdo_oe));

  // ****************************************
  // clock and shared tasks
  // ****************************************
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // every load also checks the captured pattern and the output enable
  task automatic load_ir(input logic [3:0] code);
    logic [63:0] cap;
    logic oe;
    bst_jtag_host_i.scan(1'b1, 4, 64'(code), cap, oe);
    check(64'(cap[3:0]), 64'h1);
    check(64'(oe), 64'h1);
    repeat (6) @(negedge sys_clk_in);
    check(64'(tdo_oe), 64'h0);
  endtask

  task automatic read_dr(input int n, input logic [63:0] din, output logic [63:0] dout);
    logic oe;
    bst_jtag_host_i.scan(1'b0, n, din, dout, oe);
    repeat (6) @(negedge sys_clk_in);
    check(64'(oe), 64'h1);
    check(64'(tdo_oe), 64'h0);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // identity path is live straight after reset, pads pass the core through
  task automatic t_id_after_reset();
    logic [63:0] d;
    bst_jtag_host_i.go_idle();
    read_dr(32, 64'h0, d);
    check(d, 64'(ID_EXP));
    check(64'(pad_val_out), 64'(core_val_in));
    check(64'(pad_oe_out), 64'(core_oe_in));
  endtask

  // capture of pins in normal mode; update must not reach the pads
  task automatic t_sample();
    logic [63:0] d;
    load_ir(4'h2);
    read_dr(N, 64'h0F, d);
    check(d, 64'hA5);
    check(64'(pad_val_out), 64'(core_val_in));
    check(64'(pad_oe_out), 64'(core_oe_in));
  endtask

  // cells drive pads in test mode, then stay driven under the bypass path
  task automatic t_extest_drive();
    logic [63:0] d;
    load_ir(4'h0);
    read_dr(N, 64'h3C, d);
    check(d, 64'hA5);
    check(64'(pad_val_out), 64'h3C);
    check(64'(pad_oe_out), 64'hFF);
    load_ir(4'h4);
    check(64'(pad_val_out), 64'h3C);
    check(64'(pad_oe_out), 64'hFF);
    read_dr(N, 64'hB3, d);
    check(d, 64'h66);
  endtask

  // one-bit path for bypass, float and a reserved code; output enables per code
  task automatic t_bypass_codes();
    logic [3:0] codes [3] = '{4'hF, 4'h3, 4'h7};
    logic [63:0] d;
    int i;
    for (i = 0; i < 3; i++) begin
      load_ir(codes[i]);
      read_dr(N, 64'hB3, d);
      check(d, 64'h66);
      check(64'(pad_oe_out), (codes[i] == 4'h3) ? 64'h0 : 64'(core_oe_in));
      check(64'(pad_val_out), 64'(core_val_in));
    end
  endtask

  // each reset source restores the state and the identity instruction
  task automatic t_resets();
    logic [63:0] d;
    int k;
    for (k = 0; k < 3; k++) begin
      load_ir(4'hF);
      @(negedge sys_clk_in);
      rst_in = (k == 0);
      sw_reset_in = (k == 1);
      por_in = (k == 2);
      repeat (4) @(negedge sys_clk_in);
      if (k == 0) begin
        check(64'(pad_oe_out), 64'h0);
      end
      rst_in = 1'b0;
      sw_reset_in = 1'b0;
      por_in = 1'b0;
      repeat (6) @(negedge sys_clk_in);
      bst_jtag_host_i.go_idle();
      read_dr(32, 64'h0, d);
      check(d, 64'(ID_EXP));
    end
  endtask

  // ****************************************
  // main sequence and hang guard
  // ****************************************
  initial begin
    err_count = 0;
    comparisons = 0;
    rst_in = 1'b1;
    sw_reset_in = 1'b0;
    por_in = 1'b0;
    pad_val_in = 8'hA5;
    core_val_in = 8'h96;
    core_oe_in = 8'h5A;
    repeat (2) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    t_id_after_reset();
    t_sample();
    t_extest_drive();
    t_bypass_codes();
    t_resets();
    wrap_up();
  end

  // a stuck run counts as a failure
  initial begin
    #200000;
    err_count++;
    wrap_up();
  end
endmodule
